// ==== rtl/pcie_irq_enable.sv ====
// interrupt set/clear enable, status and mask registers with an AHB-Lite slave port
//
// Overview of operation
// - bits 27..16 arm pad twelve..one rises
// - bit 10 arms secondary supply going high
// - bit 9 arms RF field activity
// - bit 8 arms primary supply going low
// - bit 7 arms secondary supply going low
// - bit 6 arms driver current limiter active
// - bits 5, 4 arm temperature sensors 1, 0
// - bit 3 arms suspend prevented event
// - bit 1 arms suspend exit event
// - bit 0 arms aggregate pad interrupt
// - clear-enable register: write one disarms source
// - status register reports pending sources, same layout
`timescale 1ns/1ps
module pcie_irq_enable #(
    parameter int SRC_W = pcie_pkg::SRC_W
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // interrupt sources, one-cycle or level events from the same clock
    input  wire logic [31:0] src_event,
    // enables to the source logic and interrupt line
    output logic      [31:0] src_enable,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // address phase capture

    pcie_pkg::pcie_req_type req_q;
    logic                   take_req;

    assign take_req = hsel & hready & (htrans == pcie_pkg::HTRANS_NONSEQ | htrans == pcie_pkg::HTRANS_SEQ);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            req_q <= '0;
        end else if (hready) begin
            req_q.valid <= take_req;
            req_q.write <= hwrite;
            req_q.addr  <= haddr[13:0];
        end
    end

    // zero wait states: every access completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    function automatic logic hit(input pcie_pkg::pcie_req_type r, input logic [13:0] off);
        hit = r.valid && (r.addr == off);
    endfunction

    logic wr_set;
    logic wr_clr;
    logic wr_mask;
    logic rd_status;

    assign wr_set    = hit(req_q, pcie_pkg::OFF_SET_EN) && req_q.write;
    assign wr_clr    = hit(req_q, pcie_pkg::OFF_CLR_EN) && req_q.write;
    assign wr_mask   = hit(req_q, pcie_pkg::OFF_IRQ_MASK) && req_q.write;
    assign rd_status = hit(req_q, pcie_pkg::OFF_STATUS) && !req_q.write;

    ////////////////////////////////////////////////////////////////////////////
    // enable register

    logic [31:0] enable_q;
    logic [31:0] enable_d;
    logic [31:0] set_bits;
    logic [31:0] clr_bits;

    // pads, supplies, rf, limiter, temperatures, suspend and aggregate share one mask
    assign set_bits = wr_set ? (hwdata & pcie_pkg::SRC_MASK) : '0;
    assign clr_bits = wr_clr ? (hwdata & pcie_pkg::SRC_MASK) : '0;

    always_comb begin
        // set beats clear when both hit the same bit in one cycle (cannot happen on one bus)
        enable_d = (enable_q & ~clr_bits) | set_bits;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            enable_q <= pcie_pkg::RESET_VAL;
        end else begin
            enable_q <= enable_d;
        end
    end

    assign src_enable = enable_q;

    ////////////////////////////////////////////////////////////////////////////
    // sticky status, clear on read, set wins

    logic [31:0] status_q;
    logic [31:0] mask_q;
    logic [31:0] new_ev;
    logic [31:0] status_left;
    logic        pending;

    assign new_ev = src_event & enable_q & pcie_pkg::SRC_MASK;
    // a read clears only what hrdata reported: a bit set after the read data was taken survives
    assign status_left = rd_status ? (status_q & ~hrdata) : status_q;
    // a set mask bit keeps its source off the line
    assign pending = |(status_q & ~mask_q);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_q <= pcie_pkg::RESET_VAL;
        end else begin
            status_q <= status_left | new_ev;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mask_q <= pcie_pkg::RESET_VAL;
        end else if (wr_mask) begin
            mask_q <= hwdata & pcie_pkg::SRC_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, registered on the address phase so it stands in the data phase

    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = '0;
        if (take_req && !hwrite) begin
            case (haddr[13:0])
                pcie_pkg::OFF_STATUS:   rdata_d = status_q;
                pcie_pkg::OFF_ENABLED:  rdata_d = enable_q;
                pcie_pkg::OFF_IRQ_MASK: rdata_d = mask_q;
                pcie_pkg::OFF_RAW:      rdata_d = src_event & pcie_pkg::SRC_MASK;
                default:                rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hrdata <= '0;
        end else if (hready) begin
            hrdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence set_write_s;
        wr_set;
    endsequence

    sequence clr_write_s;
        wr_clr;
    endsequence

    // status word taken on the address phase, then handed over and cleared in the data phase
    sequence status_addr_s;
        take_req && !hwrite && (haddr[13:0] == pcie_pkg::OFF_STATUS);
    endsequence

    sequence status_read_s;
        rd_status;
    endsequence

    set_arms_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        set_write_s |=> ((enable_q & $past(hwdata) & pcie_pkg::SRC_MASK) == ($past(hwdata) & pcie_pkg::SRC_MASK)))
        else $error("set-enable write did not arm source");

    pad_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_set && hwdata[pcie_pkg::PAD_LO] |=> enable_q[pcie_pkg::PAD_LO])
        else $error("pad one not armed");

    pad_top_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_set && hwdata[pcie_pkg::PAD_HI] |=> enable_q[pcie_pkg::PAD_HI])
        else $error("pad twelve not armed");

    sec_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_set && hwdata[pcie_pkg::SEC_HIGH_BIT] |=> enable_q[pcie_pkg::SEC_HIGH_BIT])
        else $error("secondary high not armed");

    rf_field_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_set && hwdata[pcie_pkg::RF_BIT] |=> enable_q[pcie_pkg::RF_BIT])
        else $error("rf field not armed");

    pri_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_set && hwdata[pcie_pkg::PRI_LOW_BIT] |=> enable_q[pcie_pkg::PRI_LOW_BIT])
        else $error("primary low not armed");

    sec_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_set && hwdata[pcie_pkg::SEC_LOW_BIT] |=> enable_q[pcie_pkg::SEC_LOW_BIT])
        else $error("secondary low not armed");

    curlim_arm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_set && hwdata[pcie_pkg::CURLIM_BIT] |=> enable_q[pcie_pkg::CURLIM_BIT])
        else $error("current limiter not armed");

    temp_arm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_set && hwdata[pcie_pkg::TEMP1_BIT] && hwdata[pcie_pkg::TEMP0_BIT]
        |=> enable_q[pcie_pkg::TEMP1_BIT] && enable_q[pcie_pkg::TEMP0_BIT])
        else $error("temperature sensor not armed");

    temp1_arm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_set && hwdata[pcie_pkg::TEMP1_BIT] |=> enable_q[pcie_pkg::TEMP1_BIT])
        else $error("temperature sensor one not armed");

    temp0_arm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_set && hwdata[pcie_pkg::TEMP0_BIT] |=> enable_q[pcie_pkg::TEMP0_BIT])
        else $error("temperature sensor zero not armed");

    susp_prev_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_set && hwdata[pcie_pkg::SUSP_PREV_BIT] |=> enable_q[pcie_pkg::SUSP_PREV_BIT])
        else $error("suspend prevented not armed");

    susp_exit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_set && hwdata[pcie_pkg::SUSP_EXIT_BIT] |=> enable_q[pcie_pkg::SUSP_EXIT_BIT])
        else $error("suspend exit not armed");

    pad_agg_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_set && hwdata[pcie_pkg::PAD_AGG_BIT] |=> enable_q[pcie_pkg::PAD_AGG_BIT])
        else $error("aggregate pad not armed");

    clr_disarm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clr_write_s |=> ((enable_q & $past(hwdata) & pcie_pkg::SRC_MASK) == 32'h0000_0000))
        else $error("clear-enable did not disarm");

    clr_agg_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clr_write_s ##0 hwdata[pcie_pkg::PAD_AGG_BIT] |=> !enable_q[pcie_pkg::PAD_AGG_BIT])
        else $error("aggregate pad still armed after clear");

    status_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (new_ev[pcie_pkg::PAD_AGG_BIT]) |=> status_q[pcie_pkg::PAD_AGG_BIT])
        else $error("armed event lost from status");

    status_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        status_addr_s |=> status_read_s ##0 (hrdata == $past(status_q)))
        else $error("status read data wrong");

    status_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        status_read_s |=> ((status_q & $past(status_q) & ~$past(hrdata)) == ($past(status_q) & ~$past(hrdata))))
        else $error("status read cleared an unreported bit");

    status_armed_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> ((status_q & ~$past(status_q) & ~$past(enable_q)) == 32'h0000_0000))
        else $error("status set for a disarmed source");

    irq_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        status_q[pcie_pkg::PAD_AGG_BIT] && !mask_q[pcie_pkg::PAD_AGG_BIT] |=> irq)
        else $error("unmasked pending source left line low");

    irq_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((status_q & ~mask_q) == 32'h0000_0000) |=> !irq)
        else $error("line high with nothing unmasked pending");

    mask_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_mask |=> (mask_q == ($past(hwdata) & pcie_pkg::SRC_MASK)))
        else $error("mask write lost");

    zero_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !wr_clr |=> ((enable_q & $past(enable_q)) == $past(enable_q)))
        else $error("enable dropped without clear");

    zero_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        set_write_s |=> ((enable_q & ~$past(hwdata)) == ($past(enable_q) & ~$past(hwdata))))
        else $error("set-enable zero bit changed an enable");

    zero_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clr_write_s |=> ((enable_q & ~$past(hwdata)) == ($past(enable_q) & ~$past(hwdata))))
        else $error("clear-enable zero bit changed an enable");

    en_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take_req && !hwrite && (haddr[13:0] == pcie_pkg::OFF_ENABLED) |=> (hrdata == $past(enable_q)))
        else $error("enable readback wrong");

    reset_en_a: assert property (@(posedge core_clk)
        !rst_n |=> (enable_q == pcie_pkg::RESET_VAL))
        else $error("reset left an enable armed");

    reset_status_a: assert property (@(posedge core_clk)
        !rst_n |=> (status_q == pcie_pkg::RESET_VAL) && !irq)
        else $error("reset left status or line set");

    status_resv_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |-> ((status_q & ~pcie_pkg::SRC_MASK) == 32'h0000_0000))
        else $error("reserved status bit set");

    reserved_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |-> ((enable_q & ~pcie_pkg::SRC_MASK) == 32'h0000_0000))
        else $error("reserved enable bit set");

endmodule

// ==== rtl/pcie_pkg.sv ====
// register map, field layout and bus types of the power/clock interrupt enable block
package pcie_pkg;
    localparam int          ADDR_W         = 14;
    localparam int          SRC_W          = 28;
    // printed offsets, all multiples of four, used as byte addresses
    localparam logic [13:0] OFF_SET_EN     = 14'h3fdc;
    localparam logic [13:0] OFF_STATUS     = 14'h3fe0;
    localparam logic [13:0] OFF_CLR_EN     = 14'h3fd8;
    localparam logic [13:0] OFF_ENABLED    = 14'h3fe4;
    localparam logic [13:0] OFF_IRQ_MASK   = 14'h3fe8;
    localparam logic [13:0] OFF_RAW        = 14'h3fec;
    // writable source bits: 27..16, 10..3, 1, 0
    localparam logic [31:0] SRC_MASK       = 32'h0fff_07fb;
    localparam logic [31:0] RESET_VAL      = 32'h0000_0000;
    localparam int          PAD_LO         = 16;
    localparam int          PAD_HI         = 27;
    localparam int          SEC_HIGH_BIT   = 10;
    localparam int          RF_BIT         = 9;
    localparam int          PRI_LOW_BIT    = 8;
    localparam int          SEC_LOW_BIT    = 7;
    localparam int          CURLIM_BIT     = 6;
    localparam int          TEMP1_BIT      = 5;
    localparam int          TEMP0_BIT      = 4;
    localparam int          SUSP_PREV_BIT  = 3;
    localparam int          SUSP_EXIT_BIT  = 1;
    localparam int          PAD_AGG_BIT    = 0;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ     = 2'h3;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [13:0] addr;
    } pcie_req_type;
endpackage

// ==== test/pcie_irq_enable_tb.sv ====
// self-checking bench for the interrupt enable, status and mask registers
`timescale 1ns/1ps
module pcie_irq_enable_tb;
    logic        core_clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] src_event;
    logic [31:0] src_enable;
    logic        irq;
    logic [31:0] rd;
    logic [31:0] rnd;
    logic [31:0] en_m;
    logic [31:0] st_m;
    int          bad_count;
    int          checks;

    pcie_irq_enable i_pcie_irq_enable (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .hsel       (hsel),
        .haddr      (haddr),
        .htrans     (htrans),
        .hwrite     (hwrite),
        .hsize      (hsize),
        .hwdata     (hwdata),
        .hready     (hreadyout),
        .hrdata     (hrdata),
        .hreadyout  (hreadyout),
        .hresp      (hresp),
        .src_event  (src_event),
        .src_enable (src_enable),
        .irq        (irq)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one single-word transfer; the data phase edge also carries read data
    task automatic bus(input logic [13:0] a, input logic wr, input logic [31:0] d);
        @(posedge core_clk);
        hsel   <= 1'b1;
        htrans <= pcie_pkg::HTRANS_NONSEQ;
        haddr  <= {18'h0, a};
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic pulse(input logic [31:0] ev);
        @(posedge core_clk);
        src_event <= ev;
        @(posedge core_clk);
        src_event <= 32'h0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        complete_run;
    end

    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        src_event = 32'h0;
        bad_count = 0;
        checks = 0;
        rnd = 32'he218;
        en_m = 32'h0;
        st_m = 32'h0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk(src_enable, pcie_pkg::RESET_VAL);
        bus(pcie_pkg::OFF_ENABLED, 1'b0, 32'h0);
        chk(rd, pcie_pkg::RESET_VAL);
        bus(pcie_pkg::OFF_IRQ_MASK, 1'b0, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
        // walk each bit, reserved ones must stay low
        for (int b = 0; b < 32; b++) begin
            bus(pcie_pkg::OFF_SET_EN, 1'b1, 32'h1 << b);
            en_m = en_m | ((32'h1 << b) & pcie_pkg::SRC_MASK);
            @(negedge core_clk);
            chk(src_enable, en_m);
        end
        bus(pcie_pkg::OFF_SET_EN, 1'b1, 32'h0);
        bus(pcie_pkg::OFF_ENABLED, 1'b0, 32'h0);
        chk(rd, en_m);
        for (int k = 0; k < 16; k++) begin
            rnd = lfsr(rnd);
            bus(k[0] ? pcie_pkg::OFF_CLR_EN : pcie_pkg::OFF_SET_EN, 1'b1, rnd);
            en_m = k[0] ? en_m & ~rnd : en_m | (rnd & pcie_pkg::SRC_MASK);
            bus(pcie_pkg::OFF_ENABLED, 1'b0, 32'h0);
            chk(rd, en_m);
        end
        $display("test enables done");
        bus(pcie_pkg::OFF_SET_EN, 1'b1, 32'h1);
        en_m = en_m | 32'h1;
        bus(pcie_pkg::OFF_STATUS, 1'b0, 32'h0);
        rnd = lfsr(rnd) | 32'h1;
        pulse(rnd);
        st_m = rnd & en_m;
        chk({31'h0, irq}, 32'h1);
        bus(pcie_pkg::OFF_STATUS, 1'b0, 32'h0);
        chk(rd, st_m);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0, irq}, 32'h0);
        bus(pcie_pkg::OFF_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h0);
        // a set mask bit keeps the line low until it is cleared
        bus(pcie_pkg::OFF_IRQ_MASK, 1'b1, pcie_pkg::SRC_MASK);
        bus(pcie_pkg::OFF_IRQ_MASK, 1'b0, 32'h0);
        chk(rd, pcie_pkg::SRC_MASK);
        pulse(32'h1);
        chk({31'h0, irq}, 32'h0);
        bus(pcie_pkg::OFF_IRQ_MASK, 1'b1, 32'h0);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0, irq}, 32'h1);
        bus(pcie_pkg::OFF_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h1);
        // raw sources read back while they stand; only armed ones reach status
        rnd = lfsr(rnd);
        src_event <= rnd;
        bus(pcie_pkg::OFF_RAW, 1'b0, 32'h0);
        chk(rd, rnd & pcie_pkg::SRC_MASK);
        src_event <= 32'h0;
        bus(pcie_pkg::OFF_STATUS, 1'b0, 32'h0);
        chk(rd, rnd & en_m);
        $display("test status done");
        bus(14'h0100, 1'b1, 32'hffff_ffff);
        bus(14'h0100, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk(src_enable, en_m);
        $display("test unmapped done");
        complete_run;
    end
endmodule
